/* verilog/cgp_pkg.sv */
// Constants, register map and mode encoding of the clock generator and PLL control
//
// Overview of operation
// - PLL mode multiplies oscillator clock by eight.
// - 2.5 MHz in gives 20 MHz or 2.5 MHz.
// - PLL select bit picks through or multiplied clock.
// - Select write while unlocked stores zero instead.
// - PLL control resets 01H; software keeps fixed bits.
// - Clock mode resets 0AH; write 0BH first.
// - Divider field gives fxx, /2, /4, /8.
// - CPU divider resets to 03H, slowest ratio.
// - Mode, divider, power-save writes need protection sequence.
// - Peripheral prescaler gives fxx down to fxx/2048.
// - CPU divided; timers fxx; watchdog fxx/512.
// - Stabilization timer counts settle then lockup time.
// - Idle stops CPU and peripheral clocks; oscillator, PLL, monitor, serial slave run.
// - Halt gates only the CPU clock.
// - Monitor detects oscillator stop; hi-Z, fail low.
// - Clock-fail low stays until reset.
// - Fail level reaches pin only when configured.
// - Wake mask clear allows interrupt wake-up.
// - Power save control resets to 00H.
// - Standby request bit enters standby; divider 03H first.
// - Stop-not-idle picks idle or stop with request.
// - After lockup start clock-through at fxx/8; code does so only after reset, stop wake-up keeps the select bit and divider.
package cgp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] IDX_CLOCK_MODE_CONTROL = 32'hfffff822;
  localparam logic [31:0] IDX_CPU_CLOCK_DIVIDER = 32'hfffff828;
  localparam logic [31:0] IDX_PLL_CONTROL = 32'hfffff830;
  localparam logic [31:0] IDX_POWER_SAVE_CONTROL = 32'hfffff831;
  localparam logic [31:0] IDX_POWER_SAVE_MODE = 32'hfffff832;
  localparam logic [31:0] IDX_STAB_SELECT = 32'hfffff833;
  localparam logic [31:0] IDX_CLOCK_MONITOR_MODE = 32'hfffff834;
  localparam logic [31:0] IDX_WRITE_PROTECT_CMD = 32'hfffff835;
  localparam logic [31:0] IDX_CLOCK_STATUS = 32'hfffff836;

  // Byte addresses derived from the indices
  localparam logic [31:0] ADDR_CLOCK_MODE_CONTROL = {IDX_CLOCK_MODE_CONTROL[29:0], 2'h0};
  localparam logic [31:0] ADDR_CPU_CLOCK_DIVIDER = {IDX_CPU_CLOCK_DIVIDER[29:0], 2'h0};
  localparam logic [31:0] ADDR_PLL_CONTROL = {IDX_PLL_CONTROL[29:0], 2'h0};
  localparam logic [31:0] ADDR_POWER_SAVE_CONTROL = {IDX_POWER_SAVE_CONTROL[29:0], 2'h0};
  localparam logic [31:0] ADDR_POWER_SAVE_MODE = {IDX_POWER_SAVE_MODE[29:0], 2'h0};
  localparam logic [31:0] ADDR_STAB_SELECT = {IDX_STAB_SELECT[29:0], 2'h0};
  localparam logic [31:0] ADDR_CLOCK_MONITOR_MODE = {IDX_CLOCK_MONITOR_MODE[29:0], 2'h0};
  localparam logic [31:0] ADDR_WRITE_PROTECT_CMD = {IDX_WRITE_PROTECT_CMD[29:0], 2'h0};
  localparam logic [31:0] ADDR_CLOCK_STATUS = {IDX_CLOCK_STATUS[29:0], 2'h0};

  // Values after reset
  localparam logic [7:0] RST_CLOCK_MODE_CONTROL = 8'h0a;
  localparam logic [7:0] RST_CPU_CLOCK_DIVIDER = 8'h03;
  localparam logic [7:0] RST_PLL_CONTROL = 8'h01;
  localparam logic [7:0] RST_POWER_SAVE_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_SAVE_MODE = 8'h00;
  localparam logic [2:0] RST_STAB_SELECT = 3'h6;

  // Fixed bits of the clock mode control register
  localparam logic [7:0] CKC_FIXED_BITS = 8'h08;

  // Field positions
  localparam int PLL_ON_BIT = 0;
  localparam int PLL_SELECT_BIT = 1;
  localparam int STANDBY_REQ_BIT = 1;
  localparam int IRQ_WAKE_MASK_BIT = 4;
  localparam int STOP_NOT_IDLE_BIT = 0;
  localparam int CLOCK_MONITOR_EN_BIT = 0;

  // Stabilization select: lowest and highest legal codes
  localparam logic [2:0] STAB_SEL_MIN = 3'h4;
  localparam logic [2:0] STAB_SEL_MAX = 3'h6;

  // Monitor oscillator edges without an oscillator edge before failing
  localparam logic [2:0] MON_LIMIT = 3'h4;

  // Prescaler width and taps
  localparam int PRESCALE_W = 11;
  localparam int PERIPH_TAPS = 12;
  localparam int WDT_TAP = 9;

  // Operating modes, Gray coded along stabilize, run, idle, stop
  typedef enum logic [1:0] {
    CGP_STAB = 2'b00,
    CGP_RUN = 2'b01,
    CGP_IDLE = 2'b11,
    CGP_STOP = 2'b10
  } cgp_mode_t;

endpackage

/* verilog/cgp_top.sv */
// Clock generator with PLL select, dividers, standby control and clock monitor
`timescale 1ns/10ps
module cgp_top #(
  parameter int unsigned STAB_BASE_COUNT = 16384 // Oscillator edges for shortest stabilization, 2^14
) (
  input wire logic hclk, // 20 MHz system clock (fxx source)
  input wire logic hresetn, // Async active-low reset
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic osc_clock, // Oscillator pin level
  input wire logic int_osc_clock, // Internal monitor oscillator level
  input wire logic halt_req, // CPU halt request, level
  input wire logic maskable_irq, // Any pending maskable interrupt
  input wire logic port1_bit6_is_port_out, // Pin set as output port
  input wire logic port1_bit6_is_timer_q_out0, // Pin set as timer Q channel 0 output
  output logic fxx_en, // System clock enable
  output logic cpu_clk_en, // CPU clock enable
  output logic fclk_en, // Internal system clock enable
  output logic timer_clk_en, // Timer and converter clock enable
  output logic wdt_clk_en, // Watchdog clock enable
  output logic [cgp_pkg::PERIPH_TAPS-1:0] periph_tick, // Peripheral taps fxx/2^k
  output logic sync_serial_slave_en, // Serial port slave may run
  output logic osc_enable, // Oscillator running
  output logic pll_enable, // PLL running
  output logic pll_locked, // PLL lock indication
  output logic sys_ready, // CPU reset release
  output logic motor_hiz, // Motor timer outputs to high impedance
  output logic clock_fail_out_n // Clock-fail pin level, active low
);
  import cgp_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [2:0] osc_sync; // Oscillator synchroniser
    logic [2:0] iosc_sync; // Monitor oscillator synchroniser
    logic osc_lvl; // Accepted oscillator level
    logic iosc_lvl; // Accepted monitor level
    logic ph_valid; // Data phase pending
    logic ph_write; // Pending transfer is a write
    logic [31:0] ph_addr; // Pending address
    logic [31:0] hrdata; // Read data
    logic prot_armed; // Command register just written
    logic [1:0] clock_mode_control; // Clock mode variable bits
    logic [1:0] cpu_clock_divider; // CPU divider field
    logic pll_on; // PLL control bit 0
    logic pll_select_bit; // PLL select bit
    logic stb; // Standby request
    logic irq_wake_mask; // Interrupt wake mask
    logic psm_stop; // Stop-not-idle
    logic [2:0] stab_sel; // Stabilization select
    logic clm_en; // Clock monitor enable
    cgp_mode_t mode; // Operating mode
    logic [17:0] stab_cnt; // Stabilization counter
    logic pll_run; // PLL started
    logic locked; // PLL locked
    logic ready; // CPU released
    logic fail; // Oscillator stop seen
    logic [2:0] mon_cnt; // Monitor edges since last osc edge
    logic [PRESCALE_W-1:0] pre_cnt; // Peripheral prescaler
    logic [2:0] cpu_cnt; // CPU divider counter
    logic fail_pin_n; // Registered clock-fail pin
  } cgp_state_t;

  cgp_state_t state_reg;
  cgp_state_t state_next;

  // Stabilization length for a select code
  function automatic logic [17:0] stab_target(input logic [2:0] sel);
    logic [2:0] eff;
    eff = (sel >= STAB_SEL_MIN && sel <= STAB_SEL_MAX) ? sel : STAB_SEL_MAX;
    return 18'(STAB_BASE_COUNT) << (eff - STAB_SEL_MIN);
  endfunction

  // Tick when the low k counter bits are all one
  function automatic logic tap_hit(input logic [PRESCALE_W-1:0] cnt, input int k);
    logic [PRESCALE_W:0] mask;
    mask = (12'(1) << k) - 12'(1);
    return ({1'b0, cnt} & mask) == mask;
  endfunction

  // Read data for a register address
  function automatic logic [31:0] read_mux(input cgp_state_t s, input logic [31:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_CLOCK_MODE_CONTROL: v = CKC_FIXED_BITS | {6'h00, s.clock_mode_control};
      ADDR_CPU_CLOCK_DIVIDER: v = {6'h00, s.cpu_clock_divider};
      ADDR_PLL_CONTROL: v = {6'h00, s.pll_select_bit, s.pll_on};
      ADDR_POWER_SAVE_CONTROL: v = {3'h0, s.irq_wake_mask, 2'h0, s.stb, 1'b0};
      ADDR_POWER_SAVE_MODE: v = {7'h00, s.psm_stop};
      ADDR_STAB_SELECT: v = {5'h00, s.stab_sel};
      ADDR_CLOCK_MONITOR_MODE: v = {7'h00, s.clm_en};
      ADDR_CLOCK_STATUS: v = {2'h0, s.mode, s.fail, s.locked, s.pll_run, s.ready};
      default: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  logic osc_rise; // Accepted oscillator rising edge
  logic iosc_rise; // Accepted monitor rising edge
  logic running; // Clocks to logic allowed
  logic cpu_hit; // CPU divider tick
  logic wr_go; // Write data phase now
  logic prot_ok; // Protected write allowed
  logic bus_take; // Address phase taken
  logic [7:0] wd; // Write data byte

  // Edge detection on filtered pin levels
  always_comb begin
    osc_rise = (state_reg.osc_sync[1] == state_reg.osc_sync[2]) && state_reg.osc_sync[2] && !state_reg.osc_lvl;
    iosc_rise = (state_reg.iosc_sync[1] == state_reg.iosc_sync[2]) && state_reg.iosc_sync[2]
      && !state_reg.iosc_lvl;
  end

  // Clock enables derived from mode and dividers
  always_comb begin
    running = state_reg.ready && (state_reg.mode == CGP_RUN);
    // Multiplied clock each cycle, or one per oscillator edge
    if (!state_reg.pll_run || state_reg.mode == CGP_STOP) begin
      fxx_en = 1'b0;
    end else if (state_reg.pll_select_bit) begin
      fxx_en = 1'b1;
    end else begin
      fxx_en = osc_rise;
    end
    cpu_hit = tap_hit({8'h00, state_reg.cpu_cnt}, int'(state_reg.cpu_clock_divider));
    fclk_en = fxx_en && running && cpu_hit;
    cpu_clk_en = fclk_en && !halt_req;
    for (int k = 0; k < PERIPH_TAPS; k++) begin
      periph_tick[k] = fxx_en && running && tap_hit(state_reg.pre_cnt, k);
    end
    timer_clk_en = periph_tick[0];
    wdt_clk_en = periph_tick[WDT_TAP];
    sync_serial_slave_en = state_reg.ready && (state_reg.mode != CGP_STOP);
    osc_enable = (state_reg.mode != CGP_STOP);
    pll_enable = state_reg.pll_run && state_reg.pll_on;
    pll_locked = state_reg.locked;
    sys_ready = state_reg.ready;
    motor_hiz = state_reg.fail;
    clock_fail_out_n = state_reg.fail_pin_n;
    hreadyout = 1'b1;
    hresp = 1'b0;
    hrdata = state_reg.hrdata;
  end

  // Next-state logic for bus, registers, modes and monitor
  always_comb begin
    state_next = state_reg;
    // Pin synchronisers; accepted level moves when stages two and three agree
    state_next.osc_sync = {state_reg.osc_sync[1:0], osc_clock};
    state_next.iosc_sync = {state_reg.iosc_sync[1:0], int_osc_clock};
    if (state_reg.osc_sync[1] == state_reg.osc_sync[2]) begin
      state_next.osc_lvl = state_reg.osc_sync[2];
    end
    if (state_reg.iosc_sync[1] == state_reg.iosc_sync[2]) begin
      state_next.iosc_lvl = state_reg.iosc_sync[2];
    end
    // Dividers advance on each system clock enable
    if (fxx_en) begin
      state_next.pre_cnt = state_reg.pre_cnt + PRESCALE_W'(1);
      state_next.cpu_cnt = state_reg.cpu_cnt + 3'h1;
    end

    // Data phase: writes land now
    wr_go = state_reg.ph_valid && state_reg.ph_write;
    wd = hwdata[7:0];
    prot_ok = state_reg.prot_armed;
    if (state_reg.ph_valid) begin
      // Any finished transfer other than a command write disarms
      state_next.prot_armed = wr_go && (state_reg.ph_addr == ADDR_WRITE_PROTECT_CMD);
    end
    if (wr_go) begin
      case (state_reg.ph_addr)
        ADDR_CLOCK_MODE_CONTROL: begin
          if (prot_ok) begin
            state_next.clock_mode_control = wd[1:0];
          end
        end
        ADDR_CPU_CLOCK_DIVIDER: begin
          if (prot_ok) begin
            state_next.cpu_clock_divider = wd[1:0];
          end
        end
        ADDR_PLL_CONTROL: begin
          state_next.pll_on = wd[PLL_ON_BIT];
          state_next.pll_select_bit = wd[PLL_SELECT_BIT] && state_reg.locked;
        end
        ADDR_POWER_SAVE_CONTROL: begin
          if (prot_ok) begin
            state_next.irq_wake_mask = wd[IRQ_WAKE_MASK_BIT];
            state_next.stb = wd[STANDBY_REQ_BIT];
            if (wd[STANDBY_REQ_BIT] && state_reg.mode == CGP_RUN) begin
              state_next.mode = state_reg.psm_stop ? CGP_STOP : CGP_IDLE;
            end
          end
        end
        ADDR_POWER_SAVE_MODE: begin
          state_next.psm_stop = wd[STOP_NOT_IDLE_BIT];
        end
        ADDR_STAB_SELECT: begin
          state_next.stab_sel = wd[2:0];
        end
        ADDR_CLOCK_MONITOR_MODE: begin
          if (prot_ok) begin
            // Enable can only be set; reset alone clears it
            state_next.clm_en = state_reg.clm_en | wd[CLOCK_MONITOR_EN_BIT];
          end
        end
        default: begin
          // Command and unmapped writes store nothing
        end
      endcase
    end

    // Address phase: capture and prepare read data
    bus_take = hsel && htrans[1] && hready;
    state_next.ph_valid = bus_take;
    if (bus_take) begin
      state_next.ph_write = hwrite;
      state_next.ph_addr = haddr;
      if (!hwrite) begin
        state_next.hrdata = read_mux(state_reg, haddr);
      end
    end

    // Mode sequencing
    case (state_reg.mode)
      CGP_STAB: begin
        // Settle time first, then PLL lockup over the second half
        if (osc_rise) begin
          state_next.stab_cnt = state_reg.stab_cnt + 18'h1;
          if (state_reg.stab_cnt + 18'h1 == (stab_target(state_reg.stab_sel) >> 1)) begin
            state_next.pll_run = 1'b1;
          end
          if (state_reg.stab_cnt + 18'h1 == stab_target(state_reg.stab_sel)) begin
            state_next.locked = 1'b1;
            state_next.ready = 1'b1;
            state_next.mode = CGP_RUN;
            state_next.stab_cnt = 18'h0;
          end
        end
      end
      CGP_RUN: begin
        // Entry to standby is handled by the register write
      end
      CGP_IDLE: begin
        if (maskable_irq && !state_reg.irq_wake_mask) begin
          state_next.mode = CGP_RUN;
          state_next.stb = 1'b0;
        end
      end
      CGP_STOP: begin
        state_next.locked = 1'b0;
        state_next.pll_run = 1'b0;
        state_next.stab_cnt = 18'h0;
        if (maskable_irq && !state_reg.irq_wake_mask) begin
          state_next.mode = CGP_STAB;
          state_next.stb = 1'b0;
        end
      end
      default: begin
        state_next.mode = CGP_STAB;
      end
    endcase

    // Clock monitor: forced off while stabilizing or stopped
    if (state_reg.clm_en && (state_reg.mode == CGP_RUN || state_reg.mode == CGP_IDLE)) begin
      if (osc_rise) begin
        state_next.mon_cnt = 3'h0;
      end else if (iosc_rise) begin
        state_next.mon_cnt = state_reg.mon_cnt + 3'h1;
        if (state_reg.mon_cnt + 3'h1 >= MON_LIMIT) begin
          state_next.fail = 1'b1;
        end
      end
    end else begin
      state_next.mon_cnt = 3'h0;
    end
    state_next.fail_pin_n = !(state_reg.fail && (port1_bit6_is_port_out || port1_bit6_is_timer_q_out0));
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.clock_mode_control <= RST_CLOCK_MODE_CONTROL[1:0];
      state_reg.cpu_clock_divider <= RST_CPU_CLOCK_DIVIDER[1:0];
      state_reg.pll_on <= RST_PLL_CONTROL[PLL_ON_BIT];
      state_reg.pll_select_bit <= RST_PLL_CONTROL[PLL_SELECT_BIT];
      state_reg.stb <= RST_POWER_SAVE_CONTROL[STANDBY_REQ_BIT];
      state_reg.irq_wake_mask <= RST_POWER_SAVE_CONTROL[IRQ_WAKE_MASK_BIT];
      state_reg.psm_stop <= RST_POWER_SAVE_MODE[STOP_NOT_IDLE_BIT];
      state_reg.stab_sel <= RST_STAB_SELECT;
      state_reg.mode <= CGP_STAB;
      state_reg.fail_pin_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_prot_write(logic [31:0] a);
    state_reg.ph_valid && state_reg.ph_write && state_reg.ph_addr == a;
  endsequence

  sequence s_stb_write;
    s_prot_write(ADDR_POWER_SAVE_CONTROL) ##0 (state_reg.prot_armed && hwdata[STANDBY_REQ_BIT]
      && state_reg.mode == CGP_RUN);
  endsequence

  a_select_gated: assert property (s_prot_write(ADDR_PLL_CONTROL) ##0 !state_reg.locked |=> !state_reg.pll_select_bit)
    else $error("PLL select stored while unlocked");
  a_pll_fast_clock: assert property (state_reg.pll_select_bit && state_reg.pll_run && state_reg.mode != CGP_STOP
    |-> fxx_en)
    else $error("PLL mode missing system clock enable");
  a_unprot_ignored: assert property (s_prot_write(ADDR_CPU_CLOCK_DIVIDER) ##0 !state_reg.prot_armed
    |=> $stable(state_reg.cpu_clock_divider))
    else $error("Divider changed without protection");
  a_cpu_div_eight: assert property (cpu_clk_en && state_reg.cpu_clock_divider == 2'h3 && state_reg.pll_select_bit
    |=> (!cpu_clk_en || state_reg.cpu_clock_divider != 2'h3)[*7])
    else $error("CPU clock not divided by eight");
  a_halt_cpu_only: assert property (halt_req && fclk_en |-> !cpu_clk_en)
    else $error("CPU clock runs during halt");
  a_idle_gating: assert property (state_reg.mode == CGP_IDLE |-> !fclk_en && periph_tick == '0 && osc_enable)
    else $error("Clocks run in idle");
  a_stop_unlock: assert property (state_reg.mode == CGP_STOP |=> !pll_locked || state_reg.mode != CGP_STOP)
    else $error("Lock kept in stop");
  a_standby_entry: assert property (s_stb_write |=> state_reg.mode == ($past(state_reg.psm_stop) ? CGP_STOP : CGP_IDLE))
    else $error("Standby mode not entered");
  a_fail_sticky: assert property (motor_hiz |=> motor_hiz ##1 motor_hiz)
    else $error("Clock fail released without reset");
  a_fail_pin: assert property (state_reg.fail && port1_bit6_is_port_out |=> !clock_fail_out_n)
    else $error("Clock-fail pin not driven low");
  a_lock_from_stab: assert property ($rose(pll_locked) |-> $past(state_reg.mode) == CGP_STAB && sys_ready)
    else $error("Lock outside stabilization");

  // Wake, pin, monitor and start-up checks
  sequence s_wake_idle;
    state_reg.mode == CGP_IDLE && maskable_irq && !state_reg.irq_wake_mask;
  endsequence

  a_wake_idle: assert property (s_wake_idle |=> state_reg.mode == CGP_RUN)
    else $error("Idle not left on unmasked interrupt");
  a_wake_masked: assert property (state_reg.mode == CGP_IDLE && state_reg.irq_wake_mask
    |=> state_reg.mode == CGP_IDLE)
    else $error("Idle left although wake is masked");
  a_fail_pin_tq: assert property (state_reg.fail && port1_bit6_is_timer_q_out0 |=> !clock_fail_out_n)
    else $error("Clock-fail pin not driven low for timer output");
  a_fail_pin_off: assert property (!port1_bit6_is_port_out && !port1_bit6_is_timer_q_out0
    |=> clock_fail_out_n)
    else $error("Clock-fail level on unconfigured pin");
  a_through_pulse: assert property (!state_reg.pll_select_bit && fxx_en ##1 !state_reg.pll_select_bit |-> !fxx_en)
    else $error("Clock-through enable longer than one cycle");
  a_stop_clocks: assert property (state_reg.mode == CGP_STOP
    |-> !fxx_en && !osc_enable && !sync_serial_slave_en)
    else $error("Clocks run in stop");
  a_hiz_monitor: assert property ($rose(motor_hiz) |-> $past(state_reg.clm_en))
    else $error("High impedance without clock monitor");
  a_start_through: assert property ($rose(sys_ready)
    |-> !state_reg.pll_select_bit && state_reg.cpu_clock_divider == RST_CPU_CLOCK_DIVIDER[1:0])
    else $error("Start-up not in clock-through at slowest divider");
  a_serial_idle: assert property (state_reg.mode == CGP_IDLE |-> sync_serial_slave_en)
    else $error("Serial slave stopped in idle");
  a_halt_periph: assert property (halt_req && fxx_en && state_reg.mode == CGP_RUN && state_reg.ready
    |-> timer_clk_en)
    else $error("Halt stopped the timer clock");

endmodule

/* testbench/cgp_osc_model.sv */
// Crystal resonator model driving the oscillator pin
`timescale 1ns/10ps
module cgp_osc_model #(
  parameter real HALF_NS = 200.0 // Half period of a 2.5 MHz resonator
) (
  input wire logic enable, // Oscillator amplifier running
  input wire logic broken, // Resonator failure injected by the bench
  output logic osc_clock
);
  // Swings only while powered and intact; a dead crystal rests low
  initial begin
    osc_clock = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      osc_clock = (enable && !broken) ? ~osc_clock : 1'b0;
    end
  end
endmodule

/* testbench/clock_generator_pll_ctrl_tb_top.sv */
// Self-checking bench of the clock generator and PLL control
`timescale 1ns/10ps
`define CGP_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module clock_generator_pll_ctrl_tb_top;
  import cgp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, int_osc, osc_clock, osc_broken;
  logic [31:0] haddr, hwdata, hrdata, seed, r0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic halt_req, irq, p_out, p_tq, fxx_en, cpu_clk_en, fclk_en, timer_clk_en, wdt_clk_en;
  logic [PERIPH_TAPS-1:0] periph_tick;
  logic sync_serial_slave_en, osc_enable, pll_enable, pll_locked, sys_ready, motor_hiz, fail_n;
  int errors, num_checks, i, k;
  int cnt [6]; // Pulse counts of fxx, fclk, cpu, timer, watchdog, fxx/2048
  logic [1:0] d;

  cgp_top #(.STAB_BASE_COUNT(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_clock(osc_clock), .int_osc_clock(int_osc),
    .halt_req(halt_req), .maskable_irq(irq), .port1_bit6_is_port_out(p_out),
    .port1_bit6_is_timer_q_out0(p_tq), .fxx_en(fxx_en), .cpu_clk_en(cpu_clk_en), .fclk_en(fclk_en),
    .timer_clk_en(timer_clk_en), .wdt_clk_en(wdt_clk_en), .periph_tick(periph_tick),
    .sync_serial_slave_en(sync_serial_slave_en), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .pll_locked(pll_locked), .sys_ready(sys_ready), .motor_hiz(motor_hiz), .clock_fail_out_n(fail_n));

  // Resonator on the far side
  cgp_osc_model u_osc (.enable(osc_enable), .broken(osc_broken), .osc_clock(osc_clock));

  // 20 MHz bus clock and an unrelated monitor oscillator
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    int_osc = 1'b0;
    forever #185 int_osc = ~int_osc;
  end

  // Fixed-seed pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Single word transfer: hold address phase, then data phase, until ready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] r;
    ahb(1'b1, a, wd, r);
  endtask

  // Command register write with random data, then the target
  task automatic pw(input logic [31:0] a, input logic [31:0] wd);
    seed = lfsr(seed);
    wr(ADDR_WRITE_PROTECT_CMD, seed);
    wr(a, wd);
  endtask

  // Read and compare the masked bits
  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CGP_CHK(r & m, e)
  endtask

  // Count enable pulses over a window, sampled mid-cycle
  task automatic measure(input int n);
    logic [5:0] v;
    cnt = '{default: 0};
    repeat (n) begin
      @(negedge hclk);
      v = {periph_tick[11], wdt_clk_en, timer_clk_en, cpu_clk_en, fclk_en, fxx_en};
      for (int j = 0; j < 6; j++) if (v[j] === 1'b1) cnt[j]++;
    end
  endtask

  task complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (80000) @(posedge hclk);
    errors++;
    complete_run;
  end

  initial begin
    {hresetn, hsel, hwrite, halt_req, irq, p_out, p_tq, osc_broken} = 8'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'h2};
    seed = 32'h41e6;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, and select refused while unlocked
    rchk(ADDR_CLOCK_MODE_CONTROL, 32'hff, 32'h0a);
    rchk(ADDR_CPU_CLOCK_DIVIDER, 32'hff, 32'h03);
    rchk(ADDR_PLL_CONTROL, 32'hff, 32'h01);
    rchk(ADDR_POWER_SAVE_CONTROL, 32'hff, 32'h00);
    rchk(ADDR_STAB_SELECT, 32'hff, 32'h06);
    wr(ADDR_PLL_CONTROL, 32'h03);
    rchk(ADDR_PLL_CONTROL, 32'hff, 32'h01);
    for (i = 0; i < 4000 && sys_ready !== 1'b1; i++) @(posedge hclk);
    `CGP_CHK(pll_locked, 1'b1)
    // Clock-through start with slowest divider
    measure(512);
    `CGP_CHK(cnt[0], 64)
    `CGP_CHK(cnt[1], 8)
    // Unprotected and interrupted sequences are ignored
    wr(ADDR_CPU_CLOCK_DIVIDER, 32'h0);
    `CGP_CHK(hresp, 1'b0)
    rchk(ADDR_CPU_CLOCK_DIVIDER, 32'hff, 32'h03);
    wr(ADDR_WRITE_PROTECT_CMD, 32'h0);
    rchk(ADDR_CLOCK_STATUS, 32'h30, 32'h10);
    wr(ADDR_CPU_CLOCK_DIVIDER, 32'h0);
    rchk(ADDR_CPU_CLOCK_DIVIDER, 32'hff, 32'h03);
    pw(ADDR_CLOCK_MODE_CONTROL, 32'hf9);
    rchk(ADDR_CLOCK_MODE_CONTROL, 32'hff, 32'h09);
    pw(ADDR_CLOCK_MODE_CONTROL, 32'h0b);
    wr(ADDR_PLL_CONTROL, 32'h03);
    rchk(ADDR_PLL_CONTROL, 32'hff, 32'h03);
    // Every divider code in random order, halt drawn at random
    seed = lfsr(seed);
    r0 = seed;
    for (k = 0; k < 4; k++) begin
      d = k[1:0] ^ r0[1:0];
      seed = lfsr(seed);
      pw(ADDR_CPU_CLOCK_DIVIDER, {30'h0, d});
      halt_req <= seed[2];
      repeat (16) @(posedge hclk);
      measure(2048);
      `CGP_CHK(cnt[0], 2048)
      `CGP_CHK(cnt[1], 2048 >> d)
      `CGP_CHK(cnt[2], seed[2] ? 0 : 2048 >> d)
      `CGP_CHK(cnt[3], 2048)
      `CGP_CHK(cnt[4], 4)
      `CGP_CHK(cnt[5], 1)
    end
    halt_req <= 1'b0;
    // Idle with wake masked, then unmasked
    pw(ADDR_CPU_CLOCK_DIVIDER, 32'h03);
    wr(ADDR_POWER_SAVE_MODE, 32'h0);
    pw(ADDR_POWER_SAVE_CONTROL, 32'h12);
    measure(256);
    `CGP_CHK(cnt[1] + cnt[3] + cnt[4], 0)
    `CGP_CHK({sync_serial_slave_en, osc_enable, pll_enable}, 3'b111)
    irq <= 1'b1;
    repeat (32) @(posedge hclk);
    rchk(ADDR_CLOCK_STATUS, 32'h30, 32'h30);
    irq <= 1'b0;
    pw(ADDR_POWER_SAVE_CONTROL, 32'h02);
    irq <= 1'b1;
    repeat (8) @(posedge hclk);
    irq <= 1'b0;
    rchk(ADDR_CLOCK_STATUS, 32'h30, 32'h10);
    rchk(ADDR_POWER_SAVE_CONTROL, 32'hff, 32'h00);
    // Stop, then wake through relock
    wr(ADDR_STAB_SELECT, 32'h4);
    wr(ADDR_POWER_SAVE_MODE, 32'h1);
    pw(ADDR_POWER_SAVE_CONTROL, 32'h02);
    repeat (4) @(posedge hclk);
    `CGP_CHK({osc_enable, pll_locked, sync_serial_slave_en}, 3'b000)
    rchk(ADDR_CLOCK_STATUS, 32'h30, 32'h20);
    irq <= 1'b1;
    repeat (4) @(posedge hclk);
    irq <= 1'b0;
    for (i = 0; i < 4000 && pll_locked !== 1'b1; i++) @(posedge hclk);
    `CGP_CHK((i > 40) && (i < 120), 1'b1)
    repeat (4) @(posedge hclk);
    rchk(ADDR_CLOCK_STATUS, 32'h30, 32'h10);
    pw(ADDR_CPU_CLOCK_DIVIDER, 32'h0);
    // Oscillator failure seen by the monitor
    pw(ADDR_CLOCK_MONITOR_MODE, 32'h1);
    osc_broken <= 1'b1;
    for (i = 0; i < 400 && motor_hiz !== 1'b1; i++) @(posedge hclk);
    `CGP_CHK({motor_hiz, fail_n}, 2'b11)
    p_out <= 1'b1;
    repeat (2) @(posedge hclk);
    `CGP_CHK(fail_n, 1'b0)
    {p_out, p_tq} <= 2'b01;
    repeat (2) @(posedge hclk);
    `CGP_CHK(fail_n, 1'b0)
    osc_broken <= 1'b0;
    repeat (200) @(posedge hclk);
    `CGP_CHK({motor_hiz, fail_n}, 2'b10)
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CGP_CHK({motor_hiz, fail_n}, 2'b01)
    complete_run;
  end
endmodule
